// ==== src/disc_cfg.sv ====
// Behaviour
// - Bandwidth register picks PLL bandwidth code, default 1001
// - Equalization register sets PLL equalization, default nominal
// - Biphase register: source, low, accuracy, flags
// - Standby floats audio, misc, clock, biphase outputs
// - Stop standby parks motor outputs; pause runs
// - Code 0000 makes pins four, five motor lines
// - Low bits set versatile output four
// - High bits set versatile output five
// - Corrector corrects two symbols, flags worse frames
// - First-stage flags help form second-stage flags
// - Second-stage flags feed biphase validity, misc and flag pins
// - Flag pin shows all correction, concealment flags
// - Pre-emphasis selects de-emphasis, else phase compensation
// - Oversampling scales output half a decibel down
// - Lone bad sample replaced by neighbour average
// - Bad runs hold, then interpolate before good
// - Left and right concealed independently
// Holds the configuration registers, serial write port, pin routing and concealment.
// Assumes the controller pins are asynchronous and the sample stream is on ref_clk.
`timescale 1ns/100ps

// Three-flop pin filter; value moves only when stages two and three agree
module pin_filter #(
	parameter int width = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Raw pins and filtered levels
	input wire logic [width-1:0] pin_in,
	output logic [width-1:0] level_q
);
	logic [width-1:0] s1_q; // First stage, read only by s2_q
	logic [width-1:0] s2_q;
	logic [width-1:0] s3_q;
	// Synchroniser chain
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Agreement filter per bit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			level_q <= '0;
		end else begin
			for (int i = 0; i < width; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule // pin_filter

// One channel of concealment; one sample of look-ahead latency
module conceal_channel (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Incoming flagged samples
	input wire logic in_valid,
	input wire logic signed [15:0] in_sample,
	input wire logic in_flag,
	// Concealed samples
	output logic signed [15:0] out_sample_q,
	output logic out_flag_q
);
	logic signed [15:0] cur_q; // Sample waiting for its successor
	logic cur_flag_q;
	logic signed [16:0] mid_sum;
	assign mid_sum = 17'(out_sample_q) + 17'(in_sample);
	// Decide the waiting sample once the next one is known
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cur_q <= '0;
			cur_flag_q <= 1'b0;
			out_sample_q <= '0;
			out_flag_q <= 1'b0;
		end else if (in_valid) begin
			cur_q <= in_sample;
			cur_flag_q <= in_flag;
			out_flag_q <= cur_flag_q;
			if (!cur_flag_q) begin
				out_sample_q <= cur_q;
			end else if (!in_flag) begin
				// Midway between held value and next good one
				out_sample_q <= mid_sum[16:1];
			end else begin
				// Run continues: keep the last good level
				out_sample_q <= out_sample_q;
			end
		end
	end
endmodule // conceal_channel

module disc_cfg (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Controller serial link
	input wire logic ctrl_serial_clock,
	input wire logic ctrl_register_strobe,
	input wire logic ctrl_serial_line_in,
	output logic ctrl_serial_line_out,
	output logic ctrl_serial_line_oe,
	// PLL and speed settings
	output logic [3:0] pll_bandwidth_code,
	output logic [3:0] pll_equalization_code,
	output logic double_speed,
	output logic xtal_half_rate,
	output logic stop_standby,
	output logic pause_standby,
	// Output enables of pins that float in standby
	output logic audio_out_oe,
	output logic misc_flag_oe,
	output logic divided_clock_oe,
	output logic biphase_oe,
	// Motor drive
	input wire logic motor_a_in,
	input wire logic motor_b_in,
	input wire logic motor_pwm_mode,
	output logic motor_drive_a_out,
	output logic motor_drive_a_oe,
	output logic motor_drive_b_out,
	output logic motor_drive_b_oe,
	// Error corrector flag stages
	input wire logic first_stage_valid,
	input wire logic [2:0] first_stage_errors,
	input wire logic second_stage_valid,
	input wire logic [2:0] second_stage_errors,
	input wire logic first_stage_flag_deint,
	output logic first_stage_code_flag,
	output logic second_stage_code_flag,
	output logic correction_flag_pin,
	output logic misc_flag_pin,
	input wire logic data_only_mode,
	// Audio stream
	input wire logic sample_valid,
	input wire logic signed [15:0] left_in,
	input wire logic signed [15:0] right_in,
	input wire logic left_flag_in,
	input wire logic right_flag_in,
	input wire logic oversample_on,
	input wire logic q_preemphasis,
	output logic signed [15:0] left_out,
	output logic signed [15:0] right_out,
	output logic deemph_section_on,
	output logic phase_comp_on,
	// Biphase output
	input wire logic biphase_encoded_in,
	output logic biphase_out_pin,
	output logic signed [15:0] biphase_left,
	output logic signed [15:0] biphase_right,
	output logic biphase_validity,
	output logic biphase_err_flags,
	output logic biphase_level3,
	// Versatile pins
	input wire logic versatile_in_one,
	input wire logic versatile_in_two,
	input wire logic silence_left,
	input wire logic silence_right,
	input wire logic subcode_serial,
	output logic offtrack,
	output logic v1_status,
	output logic v2_status,
	output logic kill_out,
	output logic versatile_out_three,
	output logic versatile_out_four,
	output logic versatile_out_five
);
	logic [4:0] pins_q; // Filtered clock, strobe, line, v1, v2
	logic sclk_prev_q;
	logic strobe_prev_q;
	logic [7:0] shift_q; // Address then data, first bit in MSB
	logic [3:0] count_q;
	logic wr_stb; // Frame complete at strobe fall
	logic [3:0] reg_bw_q, reg_eq_q, reg_bp_q, reg_sp_q, reg_va_q, reg_vb_q;
	disc_cfg_pkg::standby_type state_q;
	logic standby;
	logic signed [15:0] cl_sample, cr_sample;
	logic cl_flag, cr_flag;
	logic signed [24:0] left_scaled, right_scaled;

	// Controller pins filtered before use
	pin_filter #(.width(5)) u_pins (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pin_in({ctrl_serial_clock, ctrl_register_strobe, ctrl_serial_line_in, versatile_in_one, versatile_in_two}),
		.level_q(pins_q)
	);

	// Edge history of filtered clock and strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= pins_q[4];
			strobe_prev_q <= pins_q[3];
		end
	end

	// Shift while strobe is high; low strobe leaves the lines to others
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shift_q <= '0;
			count_q <= '0;
		end else if (!pins_q[3]) begin
			count_q <= '0;
		end else if (pins_q[4] && !sclk_prev_q && count_q != disc_cfg_pkg::frame_bits) begin
			shift_q <= {shift_q[6:0], pins_q[2]};
			count_q <= count_q + 4'h1;
		end
	end
	// Only a full eight-bit frame writes; short frames are dropped
	assign wr_stb = strobe_prev_q && !pins_q[3] && count_q == disc_cfg_pkg::frame_bits;

	// Registers are write only, so the data line is never driven
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_serial_line_out <= 1'b0;
			ctrl_serial_line_oe <= 1'b0;
		end else begin
			ctrl_serial_line_out <= 1'b0;
			ctrl_serial_line_oe <= 1'b0;
		end
	end

	// Register file; unlisted codes are stored as written
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_bw_q <= disc_cfg_pkg::rst_bandwidth;
			reg_eq_q <= disc_cfg_pkg::rst_equalization;
			reg_bp_q <= disc_cfg_pkg::rst_biphase;
			reg_sp_q <= disc_cfg_pkg::rst_speed;
			reg_va_q <= disc_cfg_pkg::rst_vers_a;
			reg_vb_q <= disc_cfg_pkg::rst_vers_b;
		end else if (wr_stb) begin
			case (shift_q[7:4])
				disc_cfg_pkg::addr_bandwidth: reg_bw_q <= shift_q[3:0];
				disc_cfg_pkg::addr_equalization: reg_eq_q <= shift_q[3:0];
				disc_cfg_pkg::addr_biphase: reg_bp_q <= shift_q[3:0];
				disc_cfg_pkg::addr_speed: reg_sp_q <= shift_q[3:0];
				disc_cfg_pkg::addr_vers_a: reg_va_q <= shift_q[3:0];
				disc_cfg_pkg::addr_vers_b: reg_vb_q <= shift_q[3:0];
				default: ; // Addresses other than 8 to d belong elsewhere
			endcase
		end
	end

	// Standby state follows the speed register low bits
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= disc_cfg_pkg::st_stop;
		end else begin
			case (reg_sp_q[1:0])
				disc_cfg_pkg::state_code_run: state_q <= disc_cfg_pkg::st_run;
				disc_cfg_pkg::state_code_pause: state_q <= disc_cfg_pkg::st_pause;
				default: state_q <= disc_cfg_pkg::st_stop; // Code 01 treated as stop
			endcase
		end
	end
	assign standby = state_q != disc_cfg_pkg::st_run;

	// Settings and pin enables
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pll_bandwidth_code <= disc_cfg_pkg::rst_bandwidth;
			pll_equalization_code <= disc_cfg_pkg::rst_equalization;
			double_speed <= 1'b0;
			xtal_half_rate <= 1'b0;
			stop_standby <= 1'b1;
			pause_standby <= 1'b0;
			audio_out_oe <= 1'b0;
			misc_flag_oe <= 1'b0;
			divided_clock_oe <= 1'b0;
			biphase_oe <= 1'b0;
		end else begin
			pll_bandwidth_code <= reg_bw_q;
			pll_equalization_code <= reg_eq_q;
			double_speed <= reg_sp_q[disc_cfg_pkg::bit_double_speed];
			xtal_half_rate <= reg_sp_q[disc_cfg_pkg::bit_half_xtal];
			stop_standby <= state_q == disc_cfg_pkg::st_stop;
			pause_standby <= state_q == disc_cfg_pkg::st_pause;
			audio_out_oe <= !standby;
			misc_flag_oe <= !standby;
			divided_clock_oe <= !standby;
			biphase_oe <= !standby;
		end
	end

	// Motor drive; stop parks low for PWM, floats for PDM
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			motor_drive_a_out <= 1'b0;
			motor_drive_b_out <= 1'b0;
			motor_drive_a_oe <= 1'b0;
			motor_drive_b_oe <= 1'b0;
		end else if (state_q == disc_cfg_pkg::st_stop) begin
			motor_drive_a_out <= 1'b0;
			motor_drive_b_out <= 1'b0;
			motor_drive_a_oe <= motor_pwm_mode;
			motor_drive_b_oe <= motor_pwm_mode;
		end else begin
			motor_drive_a_out <= motor_a_in;
			motor_drive_b_out <= motor_b_in;
			motor_drive_a_oe <= 1'b1;
			motor_drive_b_oe <= 1'b1;
		end
	end

	// Flag controller: more than two bad symbols is uncorrectable
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			first_stage_code_flag <= 1'b0;
			second_stage_code_flag <= 1'b0;
		end else begin
			if (first_stage_valid) begin
				first_stage_code_flag <= first_stage_errors > disc_cfg_pkg::max_correctable;
			end
			if (second_stage_valid) begin
				// A corrected frame built on flagged input stays suspect
				second_stage_code_flag <= second_stage_errors > disc_cfg_pkg::max_correctable ||
					(second_stage_errors != 3'h0 && first_stage_flag_deint);
			end
		end
	end

	// Separate interpolators per channel
	conceal_channel u_conceal_left (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.in_valid(sample_valid),
		.in_sample(left_in),
		.in_flag(left_flag_in),
		.out_sample_q(cl_sample),
		.out_flag_q(cl_flag)
	);
	conceal_channel u_conceal_right (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.in_valid(sample_valid),
		.in_sample(right_in),
		.in_flag(right_flag_in),
		.out_sample_q(cr_sample),
		.out_flag_q(cr_flag)
	);

	// Level scaling avoids overflow on full-scale sines when oversampling
	assign left_scaled = (25'(cl_sample) * 25'(disc_cfg_pkg::scale_num)) >>> disc_cfg_pkg::scale_shift;
	assign right_scaled = (25'(cr_sample) * 25'(disc_cfg_pkg::scale_num)) >>> disc_cfg_pkg::scale_shift;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			left_out <= '0;
			right_out <= '0;
			deemph_section_on <= 1'b0;
			phase_comp_on <= 1'b1;
		end else begin
			left_out <= oversample_on ? left_scaled[15:0] : cl_sample;
			right_out <= oversample_on ? right_scaled[15:0] : cr_sample;
			deemph_section_on <= q_preemphasis;
			phase_comp_on <= !q_preemphasis;
		end
	end

	// Biphase source, flags and pin
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			biphase_left <= '0;
			biphase_right <= '0;
			biphase_validity <= 1'b0;
			biphase_err_flags <= 1'b0;
			biphase_level3 <= 1'b0;
			biphase_out_pin <= 1'b0;
		end else begin
			if (reg_bp_q[1:0] == disc_cfg_pkg::biphase_before) begin
				biphase_left <= left_in;
				biphase_right <= right_in;
			end else begin
				biphase_left <= left_out;
				biphase_right <= right_out;
			end
			biphase_validity <= second_stage_code_flag;
			biphase_err_flags <= reg_bp_q[disc_cfg_pkg::bit_flags_in_biphase] && correction_flag_pin;
			biphase_level3 <= reg_bp_q[disc_cfg_pkg::bit_accuracy_level];
			biphase_out_pin <= (reg_bp_q[1:0] == disc_cfg_pkg::biphase_low) ? 1'b0 : biphase_encoded_in;
		end
	end

	// Summary flag pins
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			correction_flag_pin <= 1'b0;
			misc_flag_pin <= 1'b0;
		end else begin
			correction_flag_pin <= first_stage_code_flag || second_stage_code_flag || cl_flag || cr_flag;
			misc_flag_pin <= data_only_mode && second_stage_code_flag;
		end
	end

	// Versatile pin routing
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			offtrack <= 1'b0;
			v1_status <= 1'b0;
			v2_status <= 1'b0;
			kill_out <= 1'b0;
			versatile_out_three <= 1'b0;
			versatile_out_four <= 1'b1;
			versatile_out_five <= 1'b1;
		end else begin
			offtrack <= reg_va_q[disc_cfg_pkg::bit_offtrack_en] && pins_q[1];
			v1_status <= pins_q[1];
			v2_status <= pins_q[0];
			if (reg_va_q[disc_cfg_pkg::bit_single_kill]) begin
				kill_out <= silence_left && silence_right;
				versatile_out_three <= reg_va_q[disc_cfg_pkg::bit_three_level];
			end else begin
				kill_out <= silence_left;
				versatile_out_three <= silence_right;
			end
			if (reg_vb_q == disc_cfg_pkg::vers_b_motor) begin
				versatile_out_four <= motor_drive_a_out;
				versatile_out_five <= motor_drive_b_out;
			end else begin
				case (reg_vb_q[1:0])
					disc_cfg_pkg::pin_code_func: versatile_out_four <= subcode_serial;
					disc_cfg_pkg::pin_code_low: versatile_out_four <= 1'b0;
					default: versatile_out_four <= 1'b1;
				endcase
				case (reg_vb_q[3:2])
					disc_cfg_pkg::pin_code_func: versatile_out_five <= deemph_section_on;
					disc_cfg_pkg::pin_code_low: versatile_out_five <= 1'b0;
					default: versatile_out_five <= 1'b1;
				endcase
			end
		end
	end

	// Checks
	// Good sample arriving right after a flagged one
	sequence s_bad_then_good;
		u_conceal_left.cur_flag_q && sample_valid && !left_flag_in;
	endsequence
	property p_data_floated;
		@(posedge ref_clk) disable iff (!rstn) !ctrl_serial_line_oe;
	endproperty
	a_data_floated: assert property (p_data_floated) else $error("data line driven");
	property p_bw_write;
		@(posedge ref_clk) disable iff (!rstn)
			wr_stb && shift_q[7:4] == disc_cfg_pkg::addr_bandwidth |-> ##2 pll_bandwidth_code == $past(shift_q[3:0], 2);
	endproperty
	a_bw_write: assert property (p_bw_write) else $error("bandwidth write lost");
	property p_standby_float;
		@(posedge ref_clk) disable iff (!rstn) standby |=> !audio_out_oe && !biphase_oe && !misc_flag_oe;
	endproperty
	a_standby_float: assert property (p_standby_float) else $error("pin driven in standby");
	property p_stop_motor;
		@(posedge ref_clk) disable iff (!rstn)
			state_q == disc_cfg_pkg::st_stop |=> !motor_drive_a_out && motor_drive_a_oe == $past(motor_pwm_mode);
	endproperty
	a_stop_motor: assert property (p_stop_motor) else $error("motor not parked");
	property p_biphase_low;
		@(posedge ref_clk) disable iff (!rstn) reg_bp_q[1:0] == disc_cfg_pkg::biphase_low |=> !biphase_out_pin;
	endproperty
	a_biphase_low: assert property (p_biphase_low) else $error("biphase pin not low");
	property p_offtrack;
		@(posedge ref_clk) disable iff (!rstn) !reg_va_q[disc_cfg_pkg::bit_offtrack_en] |=> !offtrack;
	endproperty
	a_offtrack: assert property (p_offtrack) else $error("off-track without enable");
	property p_flag_pin;
		@(posedge ref_clk) disable iff (!rstn) (cl_flag || cr_flag) |=> correction_flag_pin;
	endproperty
	a_flag_pin: assert property (p_flag_pin) else $error("flag pin missed concealment");
	property p_second_flag;
		@(posedge ref_clk) disable iff (!rstn)
			second_stage_valid && second_stage_errors > disc_cfg_pkg::max_correctable |=> second_stage_code_flag;
	endproperty
	a_second_flag: assert property (p_second_flag) else $error("uncorrectable frame not flagged");
	property p_lone_avg;
		@(posedge ref_clk) disable iff (!rstn)
			s_bad_then_good |=>
			cl_sample == 16'(($past(17'(cl_sample)) + $past(17'(left_in))) >>> 1);
	endproperty
	a_lone_avg: assert property (p_lone_avg) else $error("interpolation value wrong");
endmodule // disc_cfg

// ==== pkg/disc_cfg_pkg.sv ====
// Constants for the disc decoder configuration and concealment block.
// Assumes a single reference clock domain; all serial pins arrive asynchronous.
package disc_cfg_pkg;
	// Register addresses on the three-wire link
	localparam logic [3:0] addr_bandwidth = 4'h8;
	localparam logic [3:0] addr_equalization = 4'h9;
	localparam logic [3:0] addr_biphase = 4'ha;
	localparam logic [3:0] addr_speed = 4'hb;
	localparam logic [3:0] addr_vers_a = 4'hc;
	localparam logic [3:0] addr_vers_b = 4'hd;
	// Power-on values
	localparam logic [3:0] rst_bandwidth = 4'h9;
	localparam logic [3:0] rst_equalization = 4'h3;
	localparam logic [3:0] rst_biphase = 4'h2;
	localparam logic [3:0] rst_speed = 4'h0;
	localparam logic [3:0] rst_vers_a = 4'h2;
	localparam logic [3:0] rst_vers_b = 4'hf;
	// Field positions
	localparam int bit_flags_in_biphase = 3;
	localparam int bit_accuracy_level = 2;
	localparam int bit_double_speed = 3;
	localparam int bit_half_xtal = 2;
	localparam int bit_offtrack_en = 0;
	localparam int bit_single_kill = 1;
	localparam int bit_three_level = 2;
	// Field codes
	localparam logic [1:0] biphase_before = 2'h0;
	localparam logic [1:0] biphase_after = 2'h2;
	localparam logic [1:0] biphase_low = 2'h3;
	localparam logic [1:0] state_code_stop = 2'h0;
	localparam logic [1:0] state_code_pause = 2'h2;
	localparam logic [1:0] state_code_run = 2'h3;
	localparam logic [1:0] pin_code_func = 2'h1;
	localparam logic [1:0] pin_code_low = 2'h2;
	localparam logic [1:0] pin_code_high = 2'h3;
	localparam logic [3:0] vers_b_motor = 4'h0;
	// Serial frame: four address bits then four data bits
	localparam logic [3:0] frame_bits = 4'h8;
	// Error corrector figures
	localparam int first_stage_symbols = 32;
	localparam int second_stage_symbols = 28;
	localparam int parity_symbols = 4;
	localparam logic [2:0] max_correctable = 3'h2;
	// Oversampling level scale 120/128
	localparam logic signed [8:0] scale_num = 9'sh078;
	localparam int scale_shift = 7;
	// Sample width
	localparam int sample_w = 16;
	// Standby states, one-hot
	typedef enum logic [2:0] {
		st_stop = 3'h1,
		st_pause = 3'h2,
		st_run = 3'h4
	} standby_type;
endpackage

// ==== sim/ctrl_model.sv ====
// Controller model: writes command frames over the three-wire link.
// Assumes the bench ref_clk; levels move only on its falling edge.
`timescale 1ns/100ps
module ctrl_model (
	// Reference clock
	input wire logic ref_clk,
	// Serial link pins
	output logic ctrl_serial_clock,
	output logic ctrl_register_strobe,
	output logic ctrl_serial_line
);
	// Six cycles per level, above the two the pin filter needs
	task automatic hold_level();
		repeat (6) @(negedge ref_clk);
	endtask
	// One frame: address then data, MSB first; callers send listed codes only
	task automatic write(input logic [3:0] addr, input logic [3:0] data);
		logic [7:0] frame;
		frame = {addr, data};
		// Foreign traffic with strobe low must be ignored
		repeat (2) begin
			ctrl_serial_clock = 1'h1;
			ctrl_serial_line = ~ctrl_serial_line;
			hold_level();
			ctrl_serial_clock = 1'h0;
			hold_level();
		end
		ctrl_register_strobe = 1'h1;
		hold_level();
		for (int i = 7; i >= 0; i--) begin
			ctrl_serial_line = frame[i];
			hold_level();
			ctrl_serial_clock = 1'h1;
			hold_level();
			ctrl_serial_clock = 1'h0;
		end
		hold_level();
		ctrl_register_strobe = 1'h0;
		// Released line no longer shows the last bit
		ctrl_serial_line = ~ctrl_serial_line;
		repeat (12) @(negedge ref_clk);
	endtask
	// Idle levels at time zero
	initial begin
		ctrl_serial_clock = 1'h0;
		ctrl_register_strobe = 1'h0;
		ctrl_serial_line = 1'h0;
	end
endmodule // ctrl_model

// ==== sim/disc_decoder_config_and_concealment_bench.sv ====
// Bench: register writes over the serial link, pin checks, concealment sequences.
// Assumes one 125 MHz clock; inputs change on its falling edge.
`timescale 1ns/100ps
module disc_decoder_config_and_concealment_bench;
	// Clock, reset and counters
	logic ref_clk = 1'h0;
	logic rstn = 1'h0;
	int miscompares = 0;
	int compares = 0;
	// Stimulus
	logic ctrl_serial_clock, ctrl_register_strobe, ctrl_serial_line_in;
	logic motor_a_in = 1'h1, motor_pwm_mode = 1'h1, first_stage_valid = 1'h0, sample_valid = 1'h0;
	logic second_stage_valid = 1'h0, first_stage_flag_deint = 1'h0;
	logic [2:0] first_stage_errors = 3'h0, second_stage_errors = 3'h0;
	logic signed [15:0] left_in = 16'sh0000, right_in = 16'sh0000;
	logic left_flag_in = 1'h0, right_flag_in = 1'h0, oversample_on = 1'h0, biphase_encoded_in = 1'h1;
	logic versatile_in_one = 1'h1, silence_right = 1'h1, subcode_serial = 1'h1;
	// Observed outputs
	logic [3:0] pll_bandwidth_code, pll_equalization_code;
	logic double_speed, xtal_half_rate, stop_standby, pause_standby, audio_out_oe, biphase_oe, offtrack;
	logic motor_drive_a_out, motor_drive_a_oe, first_stage_code_flag, correction_flag_pin, biphase_out_pin;
	logic biphase_level3, versatile_out_three, versatile_out_four, versatile_out_five;
	logic second_stage_code_flag, biphase_validity, biphase_err_flags;
	logic signed [15:0] left_out, right_out;
	// Concealment table: left flagged at 1, 3, 4; right flagged at 1 only
	logic [15:0] lv [7] = '{16'h0064, 16'h7fff, 16'h012c, 16'h7fff, 16'h7fff, 16'h0258, 16'h02bc};
	logic [15:0] le [6] = '{16'h0064, 16'h00c8, 16'h012c, 16'h012c, 16'h01c2, 16'h0258};
	logic [6:0] lf = 7'h1a;
	// Clock: 8 ns period
	always #4 ref_clk = ~ref_clk;
	ctrl_model ctrl_model_inst (.ref_clk, .ctrl_serial_clock, .ctrl_register_strobe,
		.ctrl_serial_line(ctrl_serial_line_in));
	disc_cfg disc_cfg_inst (.ref_clk, .rstn, .ctrl_serial_clock, .ctrl_register_strobe, .ctrl_serial_line_in,
		.ctrl_serial_line_out(), .ctrl_serial_line_oe(), .pll_bandwidth_code, .pll_equalization_code,
		.double_speed, .xtal_half_rate, .stop_standby, .pause_standby, .audio_out_oe, .misc_flag_oe(),
		.divided_clock_oe(), .biphase_oe, .motor_a_in, .motor_b_in(1'h0), .motor_pwm_mode, .motor_drive_a_out,
		.motor_drive_a_oe, .motor_drive_b_out(), .motor_drive_b_oe(), .first_stage_valid, .first_stage_errors,
		.second_stage_valid, .second_stage_errors, .first_stage_flag_deint,
		.first_stage_code_flag, .second_stage_code_flag, .correction_flag_pin, .misc_flag_pin(),
		.data_only_mode(1'h0), .sample_valid, .left_in, .right_in, .left_flag_in, .right_flag_in,
		.oversample_on, .q_preemphasis(1'h0), .left_out, .right_out, .deemph_section_on(), .phase_comp_on(),
		.biphase_encoded_in, .biphase_out_pin, .biphase_left(), .biphase_right(), .biphase_validity,
		.biphase_err_flags, .biphase_level3, .versatile_in_one, .versatile_in_two(1'h0),
		.silence_left(1'h0), .silence_right, .subcode_serial, .offtrack, .v1_status(), .v2_status(),
		.kill_out(), .versatile_out_three, .versatile_out_four, .versatile_out_five);
	// One compare for every kind of value
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One sample pair; the result of the previous pair is settled on return
	task automatic smp(input logic [15:0] l, input logic [15:0] r, input logic fl, input logic fr);
		sample_valid = 1'h1;
		left_in = l;
		right_in = r;
		left_flag_in = fl;
		right_flag_in = fr;
		@(negedge ref_clk);
		sample_valid = 1'h0;
		repeat (2) @(negedge ref_clk);
	endtask
	// One frame of either stage with an error count and de-interleaved flag
	task automatic frame(input logic two, input logic [2:0] e, input logic d);
		first_stage_valid = !two;
		second_stage_valid = two;
		first_stage_errors = e;
		second_stage_errors = e;
		first_stage_flag_deint = d;
		@(negedge ref_clk);
		first_stage_valid = 1'h0;
		second_stage_valid = 1'h0;
		repeat (3) @(negedge ref_clk);
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 13 us
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		repeat (5) @(negedge ref_clk);
		rstn = 1'h1;
		repeat (2) @(negedge ref_clk);
		chk("bw", 16'h9, pll_bandwidth_code);
		chk("eq", 16'h3, pll_equalization_code);
		chk("stop", 16'h1, stop_standby);
		chk("audio_oe", 16'h0, audio_out_oe);
		chk("v3", 16'h0, versatile_out_three);
		chk("v4v5", 16'h3, {versatile_out_four, versatile_out_five});
		ctrl_model_inst.write(4'hb, 4'hf);
		chk("speed", 16'hc, {double_speed, xtal_half_rate, stop_standby, pause_standby});
		chk("oe_run", 16'h3, {audio_out_oe, biphase_oe});
		ctrl_model_inst.write(4'ha, 4'h3);
		chk("bp_low", 16'h0, biphase_out_pin);
		ctrl_model_inst.write(4'ha, 4'hc);
		chk("bp_raw", 16'h3, {biphase_out_pin, biphase_level3});
		ctrl_model_inst.write(4'hd, 4'he);
		chk("v4v5", 16'h1, {versatile_out_four, versatile_out_five});
		ctrl_model_inst.write(4'hd, 4'h9);
		chk("v4v5", 16'h2, {versatile_out_four, versatile_out_five});
		ctrl_model_inst.write(4'hc, 4'h5);
		chk("vers_a", 16'h3, {offtrack, versatile_out_three});
		ctrl_model_inst.write(4'hc, 4'h2);
		chk("vers_a", 16'h0, {offtrack, versatile_out_three});
		ctrl_model_inst.write(4'h8, 4'he);
		ctrl_model_inst.write(4'h9, 4'h5);
		chk("bw", 16'he, pll_bandwidth_code);
		chk("eq", 16'h5, pll_equalization_code);
		for (int i = 0; i < 7; i++) begin
			smp(lv[i], (i == 1) ? 16'h7fff : 16'(10 * i), lf[i], i == 1);
			if (i > 0) chk("left", le[i - 1], left_out);
			if (i > 0) chk("right", 16'(10 * (i - 1)), right_out);
		end
		oversample_on = 1'h1;
		repeat (2) smp(16'h0400, 16'h0400, 1'h0, 1'h0);
		chk("scaled", 16'h03c0, left_out);
		frame(1'h0, 3'h3, 1'h0);
		chk("c1flag", 16'h3, {first_stage_code_flag, correction_flag_pin});
		frame(1'h0, 3'h2, 1'h0);
		chk("c1flag", 16'h0, {first_stage_code_flag, correction_flag_pin});
		frame(1'h1, 3'h1, 1'h1);
		chk("c2flag", 16'h7, {second_stage_code_flag, biphase_validity, biphase_err_flags});
		frame(1'h1, 3'h1, 1'h0);
		chk("c2flag", 16'h0, {second_stage_code_flag, biphase_validity, biphase_err_flags});
		frame(1'h1, 3'h3, 1'h0);
		chk("c2flag", 16'h7, {second_stage_code_flag, biphase_validity, correction_flag_pin});
		ctrl_model_inst.write(4'hb, 4'h2);
		chk("pause", 16'h4, {pause_standby, audio_out_oe, biphase_oe});
		chk("pause_motor", 16'h3, {motor_drive_a_out, motor_drive_a_oe});
		ctrl_model_inst.write(4'hb, 4'h0);
		chk("stop_pwm", 16'h1, {motor_drive_a_out, motor_drive_a_oe});
		motor_pwm_mode = 1'h0;
		repeat (3) @(negedge ref_clk);
		chk("stop_pdm", 16'h0, motor_drive_a_oe);
		report_and_stop();
	end
endmodule // disc_decoder_config_and_concealment_bench
